//--- core/trig_pkg.sv
// Package: constants, modes, register map and carriers for trigger/exposure control
package trig_pkg;
	// Clock and timing
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned LED_TIME_MS = 100;
	localparam int unsigned LED_CYCLES = (CLK_HZ / 1000) * LED_TIME_MS;
	localparam int unsigned CNT_W = 24;
	localparam int unsigned PIX_W = 10;
	localparam logic [PIX_W-1:0] PATTERN_STEP = 10'h004;
	// Shutter switch codes
	localparam logic [3:0] SW_CONTINUOUS = 4'h0;
	localparam logic [3:0] SW_WIDTH = 4'h9;
	// Register offsets (byte addresses)
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] WIDTH_OFS = 8'h08;
	// Control field positions
	localparam int unsigned CTRL_SW_LSB = 0;
	localparam int unsigned CTRL_ASYNC_BIT = 4;
	localparam int unsigned CTRL_WIDTH_EN_BIT = 5;
	localparam int unsigned CTRL_LINK_INV_BIT = 6;
	localparam int unsigned CTRL_STROBE_EN_BIT = 7;
	localparam int unsigned CTRL_PATTERN_BIT = 8;
	localparam int unsigned CTRL_DOUBLE_BIT = 9;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0011;
	typedef enum logic [1:0] {
		MODE_CONTINUOUS,
		MODE_PRESET,
		MODE_WIDTH
	} exp_mode_e;
	typedef struct packed {
		logic [3:0] shutter_sw;
		logic async_mode;
		logic width_exposure_enable;
		logic link_invert;
		logic strobe_enable;
		logic pattern_enable;
		logic double_pulse_option;
	} ctrl_s;
	typedef struct packed {
		logic valid;
		logic [PIX_W-1:0] data;
	} pixel_s;
endpackage : trig_pkg

//--- core/trigger_exposure_control.sv
// Trigger, exposure, indicator, strobe and test-pattern control with APB registers
// Contract
// - Asynchronous mode: 100 ms indicator on falling edge
// - New falling edge restarts indicator one-shot
// - Only trailing edge triggers; one period per pulse
// - Red indicator only in asynchronous mode
// - Switch 1-8 preset; 9 width if enabled
// - Switch 0 gives continuous output, no shutter
// - Preset exposure starts at trigger rising edge
// - Width sampled on line sync trailing edge
// - Exposure n lines, floor of low time, n>=1
// - Width exposure uncertain by one line
// - Optional inversion of link trigger polarity
// - Connector trigger always active low
// - Continuous strobe only when enabled, default off
// - Test pattern replaces sensor data
// - Pattern steps four per pixel, wraps 1023
// - Triggers combined as active-low OR
// - Pattern bypasses gain and offset
module trigger_exposure_control #(
	parameter int unsigned LED_CYCLES = trig_pkg::LED_CYCLES,
	parameter int unsigned PRESET_LINES = 16,
	parameter int unsigned CONT_LINES = 32,
	parameter int unsigned WIDTH_W = 16
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Trigger inputs
	input wire logic connector_trigger_n,
	input wire logic link_trigger_in,
	// Sensor timing and video
	input wire logic line_sync,
	input wire logic [trig_pkg::PIX_W-1:0] sensor_data,
	input wire logic sensor_valid,
	// Outputs
	output logic exposure_q,
	output logic strobe_out,
	output logic red_led_q,
	output trig_pkg::pixel_s video_q
);
	trig_pkg::ctrl_s ctrl_q;
	logic [31:0] ctrl_raw_q;
	logic [1:0] conn_sync_q;
	logic [1:0] link_sync_q;
	logic [1:0] line_sync_q;
	logic trig_prev_q;
	logic line_prev_q;
	logic [trig_pkg::CNT_W-1:0] led_cnt_q;
	logic [WIDTH_W-1:0] exp_cnt_q;
	logic [WIDTH_W-1:0] meas_lines;
	logic meas_done;
	logic [trig_pkg::PIX_W-1:0] pattern_q;
	logic strobe_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;

	// Control register mapped onto the packed struct
	assign ctrl_q.shutter_sw = ctrl_raw_q[trig_pkg::CTRL_SW_LSB +: 4];
	assign ctrl_q.async_mode = ctrl_raw_q[trig_pkg::CTRL_ASYNC_BIT];
	assign ctrl_q.width_exposure_enable = ctrl_raw_q[trig_pkg::CTRL_WIDTH_EN_BIT];
	assign ctrl_q.link_invert = ctrl_raw_q[trig_pkg::CTRL_LINK_INV_BIT];
	assign ctrl_q.strobe_enable = ctrl_raw_q[trig_pkg::CTRL_STROBE_EN_BIT];
	assign ctrl_q.pattern_enable = ctrl_raw_q[trig_pkg::CTRL_PATTERN_BIT];
	assign ctrl_q.double_pulse_option = ctrl_raw_q[trig_pkg::CTRL_DOUBLE_BIT];

	// APB decode: registered response, one wait state per access
	wire apb_access = psel && penable;
	wire hit_ctrl = paddr == trig_pkg::CTRL_OFS;
	wire hit_status = paddr == trig_pkg::STATUS_OFS;
	wire hit_width = paddr == trig_pkg::WIDTH_OFS;
	wire hit_any = hit_ctrl || hit_status || hit_width;
	wire ctrl_we = apb_access && pwrite && hit_ctrl && !pready_q;

	// Synchronisers: first stage read only by second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conn_sync_q <= 2'b11;
			link_sync_q <= 2'b00;
			line_sync_q <= 2'b00;
		end else begin
			conn_sync_q <= {conn_sync_q[0], connector_trigger_n};
			link_sync_q <= {link_sync_q[0], link_trigger_in};
			line_sync_q <= {line_sync_q[0], line_sync};
		end
	end

	// Link trigger normalised to active low
	wire link_n = ctrl_q.link_invert ? !link_sync_q[1] : link_sync_q[1];
	wire conn_n = conn_sync_q[1];
	wire trig_n = conn_n && link_n;
	wire trig_fall = trig_prev_q && !trig_n;
	wire trig_rise = !trig_prev_q && trig_n;
	wire line_end = line_prev_q && !line_sync_q[1];

	// Mode selection
	function automatic trig_pkg::exp_mode_e pick_mode(input trig_pkg::ctrl_s c);
		if (c.shutter_sw == trig_pkg::SW_CONTINUOUS || !c.async_mode) begin
			pick_mode = trig_pkg::MODE_CONTINUOUS;
		end else if (c.shutter_sw == trig_pkg::SW_WIDTH && c.width_exposure_enable) begin
			pick_mode = trig_pkg::MODE_WIDTH;
		end else begin
			pick_mode = trig_pkg::MODE_PRESET;
		end
	endfunction : pick_mode

	trig_pkg::exp_mode_e mode;
	assign mode = pick_mode(ctrl_q);
	wire [1:0] mode_sel = mode;
	wire is_async = ctrl_q.async_mode && ctrl_q.shutter_sw != trig_pkg::SW_CONTINUOUS;

	// Read-back selection
	wire [31:0] status_word = {26'h0, strobe_q, red_led_q, exposure_q, trig_prev_q,
		mode_sel};
	wire [31:0] rd_mux = hit_ctrl ? ctrl_raw_q :
		hit_status ? status_word :
		hit_width ? {{(32 - WIDTH_W){1'b0}}, meas_lines} : 32'h0000_0000;

	width_meter #(
		.W(WIDTH_W)
	) u_meter (
		.pclk(pclk),
		.presetn(presetn),
		.line_end(line_end),
		.trig_n(trig_n),
		.lines_q(meas_lines),
		.done_q(meas_done)
	);

	// Exposure start and length per mode
	wire cont_start = (mode == trig_pkg::MODE_CONTINUOUS) && line_end && exp_cnt_q == '0;
	wire preset_start = (mode == trig_pkg::MODE_PRESET) && trig_rise;
	wire width_start = (mode == trig_pkg::MODE_WIDTH) && meas_done;
	wire [WIDTH_W-1:0] start_len = width_start ? meas_lines :
		preset_start ? WIDTH_W'(PRESET_LINES) : WIDTH_W'(CONT_LINES);
	wire exp_start = cont_start || preset_start || width_start;
	wire exp_last = line_end && exp_cnt_q == WIDTH_W'(1);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trig_prev_q <= 1'b1;
			line_prev_q <= 1'b0;
			exp_cnt_q <= '0;
			exposure_q <= 1'b0;
		end else begin
			trig_prev_q <= trig_n;
			line_prev_q <= line_sync_q[1];
			if (exp_start) begin
				exp_cnt_q <= start_len;
				exposure_q <= 1'b1;
			end else if (exp_last) begin
				exp_cnt_q <= '0;
				exposure_q <= 1'b0;
			end else if (line_end && exp_cnt_q != '0) begin
				exp_cnt_q <= exp_cnt_q - WIDTH_W'(1);
			end
		end
	end

	// Strobe follows exposure; continuous mode only if enabled
	wire strobe_d = exp_start || (exposure_q && !exp_last);
	wire strobe_allow = (mode != trig_pkg::MODE_CONTINUOUS) || ctrl_q.strobe_enable;
	assign strobe_out = strobe_q;

	// Retriggerable indicator one-shot
	wire led_fire = is_async && trig_fall;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			led_cnt_q <= '0;
			red_led_q <= 1'b0;
			strobe_q <= 1'b0;
		end else begin
			strobe_q <= strobe_d && strobe_allow;
			if (led_fire) begin
				led_cnt_q <= trig_pkg::CNT_W'(LED_CYCLES - 1);
				red_led_q <= 1'b1;
			end else if (!is_async || led_cnt_q == '0) begin
				led_cnt_q <= '0;
				red_led_q <= 1'b0;
			end else begin
				led_cnt_q <= led_cnt_q - trig_pkg::CNT_W'(1);
			end
		end
	end

	// Sawtooth pattern replaces sensor data, bypassing gain and offset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pattern_q <= '0;
			video_q <= '0;
		end else begin
			if (line_end) begin
				pattern_q <= '0;
			end else if (sensor_valid) begin
				pattern_q <= pattern_q + trig_pkg::PATTERN_STEP;
			end
			video_q.valid <= sensor_valid;
			video_q.data <= ctrl_q.pattern_enable ? pattern_q : sensor_data;
		end
	end

	// APB slave registers
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_raw_q <= trig_pkg::CTRL_RESET;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= apb_access && !pready_q;
			pslverr_q <= apb_access && !pready_q && !hit_any;
			prdata_q <= (apb_access && !pwrite && !pready_q) ? rd_mux : 32'h0000_0000;
			if (ctrl_we) begin
				ctrl_raw_q <= {22'h0, pwdata[9:0]};
			end
		end
	end
endmodule : trigger_exposure_control

//--- core/width_meter.sv
// Line-sampled low-time measurement of the combined trigger
module width_meter #(
	parameter int unsigned W = 16
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Sampling
	input wire logic line_end,
	input wire logic trig_n,
	// Result
	output logic [W-1:0] lines_q,
	output logic done_q
);
	logic [W-1:0] count_q;
	logic low_seen_q;
	wire sample_low = line_end && !trig_n;
	wire sample_high = line_end && trig_n;
	wire finish = sample_high && low_seen_q;
	// Whole lines below at least one, n >= 1
	wire [W-1:0] clamp = (count_q == '0) ? W'(1) : count_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= '0;
			low_seen_q <= 1'b0;
			lines_q <= '0;
			done_q <= 1'b0;
		end else begin
			done_q <= finish;
			if (finish) begin
				lines_q <= clamp;
			end
			if (sample_low) begin
				count_q <= (count_q == '1) ? count_q : count_q + W'(1);
				low_seen_q <= 1'b1;
			end else if (sample_high) begin
				count_q <= '0;
				low_seen_q <= 1'b0;
			end
		end
	end
endmodule : width_meter

//--- verification/tb.sv
// Self-checking bench for the trigger and exposure control block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, line_sync, connector_trigger_n, exposure_q, strobe_out, red_led_q;
	logic link_trigger_in = 1'b1, sensor_valid = 1'b0, go = 1'b0, pat_on = 1'b0;
	logic strobe_seen = 1'b0;
	logic [9:0] sensor_data = 10'h000, last_pix = 10'h000;
	logic [2:0] lines = 3'h1;
	trig_pkg::pixel_s video_q;
	logic [32:0] expq[$];
	int mismatches = 0, checks_done = 0;
	trigger_exposure_control #(.LED_CYCLES(20), .PRESET_LINES(2), .CONT_LINES(2)) u_dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.connector_trigger_n(connector_trigger_n), .link_trigger_in(link_trigger_in),
		.line_sync(line_sync), .sensor_data(sensor_data), .sensor_valid(sensor_valid),
		.exposure_q(exposure_q), .strobe_out(strobe_out), .red_led_q(red_led_q),
		.video_q(video_q));
	trig_source #(.P(16)) u_src (.pclk(pclk), .go(go), .lines(lines), .line_sync(line_sync),
		.connector_trigger_n(connector_trigger_n));
	always #5 pclk = ~pclk;
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [32:0] exp);
		expq.push_back(exp);
		apb(1'b0, a, 32'h0);
	endtask : rd
	task automatic pulse(input logic [2:0] l);
		lines <= l;
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
	endtask : pulse
	// Read results and stream checks
	always @(posedge pclk) begin
		if (pready === 1'b1 && pwrite === 1'b0) check({pslverr, prdata}, expq.pop_front());
		if (strobe_out === 1'b1) strobe_seen <= 1'b1;
		if (video_q.valid === 1'b1) begin
			last_pix <= video_q.data;
			if (pat_on) check(video_q.data == last_pix + 10'h004 || video_q.data == 0, 1);
		end
	end
	initial begin
		repeat (20000) @(posedge pclk);
		mismatches++;
		complete_run();
	end
	initial begin
		void'($urandom(42019));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(8'h00, {1'b0, trig_pkg::CTRL_RESET});
		rd(8'h0C, {1'b1, 32'h0});
		apb(1'b1, 8'h00, 32'hFFFF_FC11);
		rd(8'h00, {1'b0, 32'h0000_0011});
		// Long pulse lights once, exposure after release
		pulse(3'h3);
		@(negedge connector_trigger_n);
		repeat (10) @(posedge pclk);
		check(red_led_q, 1'b1);
		repeat (30) @(posedge pclk);
		check({red_led_q, exposure_q}, 2'b00);
		@(posedge connector_trigger_n);
		repeat (8) @(posedge pclk);
		check({red_led_q, exposure_q}, 2'b01);
		apb(1'b1, 8'h00, 32'h0000_0001);
		pulse(3'h1);
		@(negedge connector_trigger_n);
		repeat (10) @(posedge pclk);
		check(red_led_q, 1'b0);
		@(posedge connector_trigger_n);
		repeat (4) @(posedge pclk);
		apb(1'b1, 8'h00, 32'h0000_0039);
		pulse(3'($urandom_range(4, 1)));
		@(posedge connector_trigger_n);
		repeat (40) @(posedge pclk);
		rd(8'h08, {1'b0, 29'h0, lines});
		apb(1'b1, 8'h00, 32'h0000_0051);
		link_trigger_in <= 1'b0;
		repeat (60) @(posedge pclk);
		rd(8'h04, {1'b0, 32'h0000_0005});
		link_trigger_in <= 1'b1;
		repeat (6) @(posedge pclk);
		rd(8'h04, {1'b0, 32'h0000_0011});
		link_trigger_in <= 1'b0;
		repeat (20) @(posedge pclk);
		apb(1'b1, 8'h00, 32'h0000_0010);
		repeat (40) @(posedge pclk);
		strobe_seen <= 1'b0;
		repeat (100) @(posedge pclk);
		check(strobe_seen, 1'b0);
		apb(1'b1, 8'h00, 32'h0000_0090);
		repeat (100) @(posedge pclk);
		check(strobe_seen, 1'b1);
		apb(1'b1, 8'h00, 32'h0000_0110);
		sensor_valid <= 1'b1;
		for (int i = 0; i < 40; i++) begin
			sensor_data <= 10'($urandom);
			pat_on <= i > 2;
			@(posedge pclk);
		end
		sensor_valid <= 1'b0;
		pat_on <= 1'b0;
		repeat (2) @(posedge pclk);
		complete_run();
	end
endmodule : tb

//--- verification/tec_properties.sv
// Port assertions for the trigger and exposure control block
module tec_checker (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bus
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Stream and outputs
	input wire logic sensor_valid,
	input wire logic exposure_q,
	input wire logic strobe_out,
	input wire logic red_led_q,
	input wire trig_pkg::pixel_s video_q
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	a_apb_answer: assert property (psel && penable && !pready |=> pready)
		else $error("no pready");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("long pready");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("stray pslverr");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("stray prdata");
	a_err_data: assert property (pslverr |-> prdata == 32'h0000_0000)
		else $error("data on error");
	a_strobe_source: assert property (strobe_out |-> exposure_q)
		else $error("strobe outside exposure");
	a_video_valid: assert property ($past(presetn) |-> video_q.valid == $past(sensor_valid))
		else $error("video valid lost");
	a_led_hold: assert property ($rose(red_led_q) |=> red_led_q [*8])
		else $error("short indicator");
endmodule : tec_checker
bind trigger_exposure_control tec_checker u_checker (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.sensor_valid(sensor_valid), .exposure_q(exposure_q), .strobe_out(strobe_out),
	.red_led_q(red_led_q), .video_q(video_q));

//--- verification/trig_source.sv
// Far-side model: line timing and a line-aligned trigger pulse
module trig_source #(
	parameter int P = 16
) (
	// Clock and command
	input wire logic pclk,
	input wire logic go,
	input wire logic [2:0] lines,
	// Far-side lines
	output logic line_sync,
	output logic connector_trigger_n
);
	timeunit 1ns;
	timeprecision 1ps;
	int n = 0;
	always @(posedge pclk) n <= (n + 1) % P;
	assign line_sync = n < P / 2;
	initial begin
		connector_trigger_n = 1'b1;
		forever begin
			@(posedge pclk);
			if (go) begin
				@(negedge line_sync);
				repeat (2) @(posedge pclk);
				connector_trigger_n <= 1'b0;
				repeat (lines * P + P / 2) @(posedge pclk);
				connector_trigger_n <= 1'b1;
			end
		end
	end
endmodule : trig_source
